// File: design/svd_pkg.sv
package svd_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_INTC = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_ENAB = 8'h0C;
    localparam logic [7:0] ADDR_PRIO = 8'h10;
    localparam logic [7:0] ADDR_LIVE = 8'h14;

    // Field positions in voltage_detect_control
    localparam int unsigned CTRL_DIR_BIT = 7;
    localparam int unsigned CTRL_STABLE_BIT = 5;
    localparam int unsigned CTRL_EN_BIT = 4;
    localparam int unsigned CTRL_LVL_LSB = 0;
    localparam int unsigned LVL_W = 4;

    // Field positions in core_interrupt_control and the peripheral group
    localparam int unsigned INTC_GIE_BIT = 7;
    localparam int unsigned INTC_PEIE_BIT = 6;
    localparam int unsigned EVT_BIT = 2;

    // Field positions in the live status word
    localparam int unsigned LIVE_COND_BIT = 0;
    localparam int unsigned LIVE_SETTLED_BIT = 1;
    localparam int unsigned LIVE_REF_BIT = 2;
    localparam int unsigned LIVE_CMP_BIT = 3;

    // Trip level code that routes the external pin to the comparator
    localparam logic [3:0] LVL_EXTERNAL = 4'hF;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic INTC_GIE_RST = 1'b0;
    localparam logic INTC_PEIE_RST = 1'b0;
    localparam logic EVT_FLAG_RST = 1'b0;
    localparam logic EVT_ENABLE_RST = 1'b0;
    localparam logic EVT_PRIO_RST = 1'b1;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Reference settle time, in ns and in mclk cycles (rounded up)
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned REF_SETTLE_NS = 20000;
    localparam int unsigned REF_SETTLE_CYC = (REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CNT_W = $clog2(REF_SETTLE_CYC + 1);
    localparam logic [SETTLE_CNT_W-1:0] SETTLE_CNT_RST = '0;

    // Software view of the detector setup
    typedef struct packed {
        logic dir;
        logic en;
        logic [LVL_W-1:0] level;
    } svd_ctrl_s;

    // Controls toward the analog comparator, divider and reference
    typedef struct packed {
        logic cmp_pwr;
        logic div_pwr;
        logic ref_en;
        logic ext_sel;
        logic [LVL_W-1:0] tap;
    } svd_ana_s;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } svd_apb_req_s;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } svd_apb_rsp_s;

endpackage : svd_pkg

// File: design/svd_settle_timer.sv
`timescale 1ns/100ps

// Counts how long the shared reference has been powered without a break
module svd_settle_timer #(
    parameter int unsigned SETTLE_CYC = svd_pkg::REF_SETTLE_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ref_on_i,
    output logic done_o
);

    logic [svd_pkg::SETTLE_CNT_W-1:0] cnt_q;
    logic [svd_pkg::SETTLE_CNT_W-1:0] cnt_d;
    logic at_end;

    // Terminal count reached; the counter parks there
    assign at_end = (cnt_q == svd_pkg::SETTLE_CNT_W'(SETTLE_CYC));

    // Any off period of the reference, whoever owned it, restarts the wait [R3] [R4]
    assign cnt_d = !ref_on_i ? svd_pkg::SETTLE_CNT_RST :
                   at_end ? cnt_q : cnt_q + svd_pkg::SETTLE_CNT_W'(1);

    // Counter register
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cnt_q <= svd_pkg::SETTLE_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Done only while the reference is still on
    assign done_o = at_end && ref_on_i;

endmodule : svd_settle_timer

// File: design/svd_ctrl.sv
`timescale 1ns/100ps

// Function
// [R1] Detector enable powers comparator and divider; clear powers both down.
// [R2] Software should enable only for short checks to save static current.
// [R3] Reference is shared with brown-out reset; any off period restarts settling.
// [R4] After reference re-enable, wait a fixed settle time before trusting detection.
// [R5] No event flag until settle time elapsed and reference reported stable.
// [R6] Supply excursions during the settle time raise no event.
// [R7] Monitoring keeps running in Sleep while enabled.
// [R8] Trip during Sleep sets event flag and requests core wake-up.
// [R9] Wake goes to interrupt vector only with global interrupt enable set.
// [R10] Any device reset returns detector registers to reset values, detector off.
// [R11] Unimplemented control bits, including bit 6, read as zero.
// [R12] Direction clear detects falling to trip; set detects rising to trip.
// [R13] Four-bit trip level selects one of sixteen trip points.
// [R14] Trip level all ones takes comparator input from external pin.
// [R15] Reference stable flag is read-only, set once circuit settled.
// [R16] Comparator output synchronised; event flag sticky until software clears.
module svd_ctrl #(
    parameter int unsigned SETTLE_CYC = svd_pkg::REF_SETTLE_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire svd_pkg::svd_apb_req_s apb_i,
    output svd_pkg::svd_apb_rsp_s apb_o,
    input wire logic cmp_i,
    input wire logic bor_ref_en_i,
    input wire logic sleep_i,
    output svd_pkg::svd_ana_s ana_o,
    output logic irq_o,
    output logic wake_o,
    output logic vec_high_o,
    output logic vec_low_o
);

    // Address decode for the error answer; the read mux decodes the offsets itself
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == svd_pkg::ADDR_CTRL) || (addr == svd_pkg::ADDR_INTC) ||
                    (addr == svd_pkg::ADDR_FLAGS) || (addr == svd_pkg::ADDR_ENAB) ||
                    (addr == svd_pkg::ADDR_PRIO) || (addr == svd_pkg::ADDR_LIVE);
    endfunction : is_mapped

    // Places one bit in an otherwise zero word
    function automatic logic [31:0] bit_word(input logic val, input int unsigned pos);
        bit_word = 32'h0000_0000;
        bit_word[pos] = val;
    endfunction : bit_word

    svd_pkg::svd_ctrl_s ctrl_q;
    svd_pkg::svd_ctrl_s ctrl_d;
    logic gie_q;
    logic gie_d;
    logic peie_q;
    logic peie_d;
    logic flag_q;
    logic flag_d;
    logic ie_q;
    logic ie_d;
    logic ip_q;
    logic ip_d;
    logic cmp_meta_q;
    logic cmp_sync_q;
    logic wake_q;
    logic wake_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] rd_word;

    logic setup_ph;
    logic access_ph;
    logic wr_acc;
    logic rd_acc;
    logic ref_on;
    logic settled;
    logic stable;
    logic trip_cond;
    logic trip_evt;
    logic rd_clear;
    logic [7:0] ctrl_byte;

    // Bus phases; every access completes with no wait state
    assign setup_ph = apb_i.psel && !apb_i.penable;
    assign access_ph = apb_i.psel && apb_i.penable;
    assign wr_acc = access_ph && apb_i.pwrite;
    assign rd_acc = access_ph && !apb_i.pwrite;

    // Reference runs while the detector or the brown-out logic needs it [R3]
    assign ref_on = ctrl_q.en || bor_ref_en_i;

    // Settle timer on the shared reference
    svd_settle_timer #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_settle (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ref_on_i(ref_on),
        .done_o(settled)
    );

    // Stable only while the detector itself is on and the wait is over [R4] [R15]
    assign stable = ctrl_q.en && settled;

    // Analog controls; both loads follow the enable bit alone [R1]
    assign ana_o.cmp_pwr = ctrl_q.en;
    assign ana_o.div_pwr = ctrl_q.en;
    assign ana_o.ref_en = ref_on;
    assign ana_o.ext_sel = (ctrl_q.level == svd_pkg::LVL_EXTERNAL); // [R14]
    assign ana_o.tap = ctrl_q.level; // [R13]

    // Two-flop synchroniser; only the second stage is looked at [R16]
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= cmp_i;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Comparator high means the sensed voltage is at or above the trip point [R12]
    assign trip_cond = ctrl_q.dir ? cmp_sync_q : !cmp_sync_q;

    // Masked until settled; runs the same way in Sleep [R5] [R6] [R7]
    assign trip_evt = trip_cond && stable;

    // A completed flag read clears only a flag it reported; a later event survives
    assign rd_clear = rd_acc && (apb_i.paddr == svd_pkg::ADDR_FLAGS) &&
                      rdata_q[svd_pkg::EVT_BIT];

    // Sticky flag; a new event in the clearing cycle wins [R16] [R8]
    assign flag_d = trip_evt || (flag_q && !rd_clear);

    // Wake request while asleep and tripping, regardless of the interrupt enables [R8]
    assign wake_d = sleep_i && trip_evt;

    // Control register write; stable bit is not writable [R15]
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_acc && (apb_i.paddr == svd_pkg::ADDR_CTRL)) begin
            ctrl_d.dir = apb_i.pwdata[svd_pkg::CTRL_DIR_BIT];
            ctrl_d.en = apb_i.pwdata[svd_pkg::CTRL_EN_BIT];
            ctrl_d.level = apb_i.pwdata[svd_pkg::CTRL_LVL_LSB +: svd_pkg::LVL_W];
        end
    end

    // Interrupt control and peripheral enable and priority writes
    assign gie_d = (wr_acc && (apb_i.paddr == svd_pkg::ADDR_INTC)) ?
                   apb_i.pwdata[svd_pkg::INTC_GIE_BIT] : gie_q;
    assign peie_d = (wr_acc && (apb_i.paddr == svd_pkg::ADDR_INTC)) ?
                    apb_i.pwdata[svd_pkg::INTC_PEIE_BIT] : peie_q;
    assign ie_d = (wr_acc && (apb_i.paddr == svd_pkg::ADDR_ENAB)) ?
                  apb_i.pwdata[svd_pkg::EVT_BIT] : ie_q;
    assign ip_d = (wr_acc && (apb_i.paddr == svd_pkg::ADDR_PRIO)) ?
                  apb_i.pwdata[svd_pkg::EVT_BIT] : ip_q;

    // Control byte as software sees it; bit 6 stays zero [R11]
    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[svd_pkg::CTRL_DIR_BIT] = ctrl_q.dir;
        ctrl_byte[svd_pkg::CTRL_STABLE_BIT] = stable; // [R15]
        ctrl_byte[svd_pkg::CTRL_EN_BIT] = ctrl_q.en;
        ctrl_byte[svd_pkg::CTRL_LVL_LSB +: svd_pkg::LVL_W] = ctrl_q.level;
    end

    // Read mux; unused bits of every word read as zero [R11]
    always_comb begin
        if (apb_i.paddr == svd_pkg::ADDR_CTRL) begin
            rd_word = {24'h00_0000, ctrl_byte};
        end else if (apb_i.paddr == svd_pkg::ADDR_INTC) begin
            rd_word = bit_word(gie_q, svd_pkg::INTC_GIE_BIT) |
                      bit_word(peie_q, svd_pkg::INTC_PEIE_BIT);
        end else if (apb_i.paddr == svd_pkg::ADDR_FLAGS) begin
            rd_word = bit_word(flag_q, svd_pkg::EVT_BIT);
        end else if (apb_i.paddr == svd_pkg::ADDR_ENAB) begin
            rd_word = bit_word(ie_q, svd_pkg::EVT_BIT);
        end else if (apb_i.paddr == svd_pkg::ADDR_PRIO) begin
            rd_word = bit_word(ip_q, svd_pkg::EVT_BIT);
        end else if (apb_i.paddr == svd_pkg::ADDR_LIVE) begin
            rd_word = bit_word(trip_cond, svd_pkg::LIVE_COND_BIT) |
                      bit_word(settled, svd_pkg::LIVE_SETTLED_BIT) |
                      bit_word(ref_on, svd_pkg::LIVE_REF_BIT) |
                      bit_word(cmp_sync_q, svd_pkg::LIVE_CMP_BIT);
        end else begin
            rd_word = svd_pkg::RDATA_RST;
        end
    end

    // Read data captured in the setup cycle so prdata comes from a flop;
    // the access-phase clear is gated by this captured copy
    assign rdata_d = setup_ph ? rd_word : rdata_q;

    // Bus answer: ready in every access cycle, error on unmapped offsets
    assign apb_o.prdata = rdata_q;
    assign apb_o.pready = access_ph;
    assign apb_o.pslverr = access_ph && !is_mapped(apb_i.paddr);

    // Registers; device reset turns the detector off [R10]
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ctrl_q <= '{dir: svd_pkg::CTRL_RST[svd_pkg::CTRL_DIR_BIT],
                        en: svd_pkg::CTRL_RST[svd_pkg::CTRL_EN_BIT],
                        level: svd_pkg::CTRL_RST[svd_pkg::CTRL_LVL_LSB +: svd_pkg::LVL_W]}; // [R10]
            gie_q <= svd_pkg::INTC_GIE_RST;
            peie_q <= svd_pkg::INTC_PEIE_RST;
            flag_q <= svd_pkg::EVT_FLAG_RST;
            ie_q <= svd_pkg::EVT_ENABLE_RST;
            ip_q <= svd_pkg::EVT_PRIO_RST;
            wake_q <= 1'b0;
            rdata_q <= svd_pkg::RDATA_RST;
        end else begin
            ctrl_q <= ctrl_d;
            gie_q <= gie_d;
            peie_q <= peie_d;
            flag_q <= flag_d;
            ie_q <= ie_d;
            ip_q <= ip_d;
            wake_q <= wake_d;
            rdata_q <= rdata_d;
        end
    end

    // Level interrupt: flag gated by its enable
    assign irq_o = flag_q && ie_q;

    // Wake request, held while asleep and tripping, one cycle after the tripping sample [R8]
    assign wake_o = wake_q;

    // Vectoring needs the global enable; otherwise the core just resumes [R9]
    assign vec_high_o = irq_o && ip_q && gie_q;
    assign vec_low_o = irq_o && !ip_q && gie_q && peie_q;

endmodule : svd_ctrl

// File: test/svd_ctrl_assertions.sv
`timescale 1ns/100ps

// Port-level watch on the detector control block
module svd_ctrl_assertions #(
    parameter int unsigned SETTLE_CYC = 4
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire svd_pkg::svd_apb_req_s apb_i,
    input wire svd_pkg::svd_apb_rsp_s apb_o,
    input wire logic cmp_i,
    input wire logic bor_ref_en_i,
    input wire logic sleep_i,
    input wire svd_pkg::svd_ana_s ana_o,
    input wire logic irq_o,
    input wire logic wake_o,
    input wire logic vec_high_o,
    input wire logic vec_low_o
);
    logic [15:0] ref_cnt_q;
    wire acc = apb_i.psel && apb_i.penable;
    wire unmap = (apb_i.paddr > svd_pkg::ADDR_LIVE) || (apb_i.paddr[1:0] != 2'b00);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Reference on-time; any off cycle restarts it, as the shared reference must
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !ana_o.ref_en) begin
            ref_cnt_q <= '0;
        end else if (ref_cnt_q <= SETTLE_CYC) begin
            ref_cnt_q <= ref_cnt_q + 16'h0001;
        end
    end
    // Analog controls, bus answer and read data shape
    property p_pwr;
        ana_o.cmp_pwr == ana_o.div_pwr && ana_o.ref_en == (ana_o.cmp_pwr || bor_ref_en_i);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power controls wrong");
    property p_ext;
        ana_o.ext_sel == (ana_o.tap == svd_pkg::LVL_EXTERNAL);
    endproperty
    a_ext: assert property (p_ext) else $error("external select wrong");
    property p_rdy;
        apb_o.pready == acc;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready wrong");
    property p_unmap;
        acc && unmap |-> apb_o.pslverr && apb_o.prdata == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
    property p_rdz;
        acc && !apb_i.pwrite |-> apb_o.prdata[31:8] == 24'h00_0000
            && (apb_i.paddr != svd_pkg::ADDR_CTRL || !apb_o.prdata[6]);
    endproperty
    a_rdz: assert property (p_rdz) else $error("unused read bits set");
    // Event timing against sleep, enable and settling
    property p_wake;
        wake_o |-> $past(sleep_i && ana_o.cmp_pwr);
    endproperty
    a_wake: assert property (p_wake) else $error("wake without sleep");
    property p_settle;
        wake_o |-> $past(ref_cnt_q) >= SETTLE_CYC;
    endproperty
    a_settle: assert property (p_settle) else $error("event before settle");
    property p_stick;
        irq_o && !acc |=> irq_o;
    endproperty
    a_stick: assert property (p_stick) else $error("event lost without read");
    property p_vec;
        vec_high_o || vec_low_o |-> irq_o && !(vec_high_o && vec_low_o);
    endproperty
    a_vec: assert property (p_vec) else $error("vector request wrong");
    c_wake: cover property (wake_o);
    c_vlo: cover property (vec_low_o);
    c_err: cover property (acc && apb_o.pslverr);
endmodule : svd_ctrl_assertions

bind svd_ctrl svd_ctrl_assertions #(.SETTLE_CYC(SETTLE_CYC)) chk_u (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .apb_i(apb_i), .apb_o(apb_o),
    .cmp_i(cmp_i), .bor_ref_en_i(bor_ref_en_i), .sleep_i(sleep_i), .ana_o(ana_o),
    .irq_o(irq_o), .wake_o(wake_o), .vec_high_o(vec_high_o), .vec_low_o(vec_low_o)
);

// File: test/svd_ctrl_tb_top.sv
`timescale 1ns/100ps

module svd_ctrl_tb_top;
    localparam int unsigned SC = 4;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cmp_i = 1'b1;
    logic bor_ref_en_i = 1'b0;
    logic sleep_i = 1'b0;
    svd_pkg::svd_apb_req_s req = '0;
    svd_pkg::svd_apb_rsp_s rsp;
    svd_pkg::svd_ana_s ana;
    logic irq, wake, vhi, vlo, err;
    logic [31:0] rd;
    logic [3:0] lvl;
    logic dir;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 5;
    int n;
    // Free-running 50 MHz clock
    always #10 mclk_i = ~mclk_i;
    svd_ctrl #(.SETTLE_CYC(SC)) dut_u (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .apb_i(req), .apb_o(rsp), .cmp_i(cmp_i),
        .bor_ref_en_i(bor_ref_en_i), .sleep_i(sleep_i), .ana_o(ana), .irq_o(irq),
        .wake_o(wake), .vec_high_o(vhi), .vec_low_o(vlo)
    );
    // Expected control word; bit 6 always zero
    function automatic logic [31:0] cw(input logic d, input logic s, input logic e,
                                       input logic [3:0] l);
        return {24'h00_0000, d, 1'b0, s, e, l};
    endfunction : cw
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    // One APB transfer; holds the request until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            k++;
        end while (rsp.pready !== 1'b1 && k < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (k >= 20) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : xfer
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        xfer(1'b0, svd_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_0000, "ctrl reset");
        xfer(1'b0, svd_pkg::ADDR_PRIO, 32'h0);
        chk(rd, 32'h0000_0004, "prio reset");
        // Every trip level, with the stable bit and bit 6 written as ones
        for (int i = 0; i < 16; i++) begin
            dir = 1'($random(seed));
            lvl = 4'(i);
            xfer(1'b1, svd_pkg::ADDR_CTRL, cw(dir, 1'b1, 1'b0, lvl) | 32'h0000_0040);
            xfer(1'b0, svd_pkg::ADDR_CTRL, 32'h0);
            chk(rd, cw(dir, 1'b0, 1'b0, lvl), "ctrl");
            chk({ana.ext_sel, ana.tap, ana.cmp_pwr, ana.ref_en}, {lvl == 4'hF, lvl, 2'b00},
                "ana");
        end
        // Trip present while settling: nothing until the settle time has run
        xfer(1'b1, svd_pkg::ADDR_ENAB, 32'h0000_0004);
        xfer(1'b1, svd_pkg::ADDR_INTC, 32'h0000_0080);
        cmp_i <= 1'b0;
        lvl = {1'b0, 3'($random(seed))};
        xfer(1'b1, svd_pkg::ADDR_CTRL, cw(1'b0, 1'b0, 1'b1, lvl));
        xfer(1'b0, svd_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0000_0000, "early flag");
        chk({ana.cmp_pwr, ana.div_pwr, ana.ref_en}, 3'b111, "power on");
        repeat (SC + 4) @(posedge mclk_i);
        chk({irq, vhi, vlo}, 3'b110, "irq");
        xfer(1'b0, svd_pkg::ADDR_CTRL, 32'h0);
        chk(rd, cw(1'b0, 1'b1, 1'b1, lvl), "stable");
        // Live word: tripping, settled, reference on, synced comparator low
        xfer(1'b0, svd_pkg::ADDR_LIVE, 32'h0);
        chk(rd, 32'h0000_0007, "live");
        cmp_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        xfer(1'b0, svd_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0000_0004, "sticky");
        xfer(1'b0, svd_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0000_0000, "cleared");
        chk(irq, 1'b0, "irq cleared");
        // Trip in sleep with interrupts globally off
        xfer(1'b1, svd_pkg::ADDR_INTC, 32'h0);
        sleep_i <= 1'b1;
        cmp_i <= 1'b0;
        n = 0;
        while (wake !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        chk(n < 20, 1'b1, "wake");
        if (n >= 20) begin
            tally_and_finish();
        end
        chk({irq, vhi, vlo}, 3'b100, "no vector");
        sleep_i <= 1'b0;
        cmp_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        xfer(1'b0, svd_pkg::ADDR_FLAGS, 32'h0);
        // Rising detection, low priority vector
        xfer(1'b1, svd_pkg::ADDR_PRIO, 32'h0);
        xfer(1'b1, svd_pkg::ADDR_INTC, 32'h0000_00C0);
        xfer(1'b1, svd_pkg::ADDR_CTRL, cw(1'b1, 1'b0, 1'b1, lvl));
        repeat (SC + 4) @(posedge mclk_i);
        chk({irq, vhi, vlo}, 3'b101, "rise");
        cmp_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        xfer(1'b0, svd_pkg::ADDR_FLAGS, 32'h0);
        xfer(1'b0, svd_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0000_0000, "fall ignored");
        // Disabled: random comparator noise raises nothing
        xfer(1'b1, svd_pkg::ADDR_CTRL, cw(1'b0, 1'b0, 1'b0, lvl)); // Short check over
        repeat (10) begin
            @(posedge mclk_i);
            cmp_i <= 1'($random(seed));
        end
        chk({ana.cmp_pwr, ana.ref_en, irq}, 3'b000, "off");
        // Reference held by brown-out logic: enable is stable at once
        bor_ref_en_i <= 1'b1;
        repeat (SC + 2) @(posedge mclk_i);
        chk(ana.ref_en, 1'b1, "shared ref");
        xfer(1'b1, svd_pkg::ADDR_CTRL, cw(1'b0, 1'b0, 1'b1, 4'hF));
        xfer(1'b0, svd_pkg::ADDR_CTRL, 32'h0);
        chk(rd, cw(1'b0, 1'b1, 1'b1, 4'hF), "shared stable");
        xfer(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
        // Reset in mid-run turns the detector off
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        xfer(1'b0, svd_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_0000, "second reset");
        chk(ana.cmp_pwr, 1'b0, "second reset power");
        tally_and_finish();
    end
endmodule : svd_ctrl_tb_top
